// [hdl/pfr_pkg.sv]
// constants and carrier types for the processor fault reporting unit
`default_nettype none
package pfr_pkg;
	// -------------------------------------------------------------------
	// fault types and subtypes
	// -------------------------------------------------------------------
	localparam logic [7:0] FT_TRACE = 8'h01;
	localparam logic [7:0] FT_OPER = 8'h02;
	localparam logic [7:0] FT_PROT = 8'h07;
	localparam logic [7:0] FT_TYPE = 8'h0A;
	localparam logic [7:0] ST_INV_OPCODE = 8'h01;
	localparam logic [7:0] ST_UNIMPL = 8'h02;
	localparam logic [7:0] ST_UNALIGNED = 8'h03;
	localparam logic [7:0] ST_INV_OPERAND = 8'h04;
	localparam logic [7:0] ST_LENGTH = 8'h02;
	localparam logic [7:0] ST_MISMATCH = 8'h01;
	// trace subtype bit positions, bit 0 reserved
	localparam int TB_INSTR = 1;
	localparam int TB_BRANCH = 2;
	localparam int TB_CALL = 3;
	localparam int TB_RETURN = 4;
	localparam int TB_PRERET = 5;
	localparam int TB_SUPER = 6;
	localparam int TB_BREAK = 7;
	localparam logic [7:0] TRACE_LEGAL = 8'hFE;
	// record offsets below the new frame pointer
	localparam logic [7:0] OFS_OPT_DATA = 8'h18;
	localparam logic [7:0] OFS_PAR_COUNT = 8'h14;
	// supervisor return status codes
	localparam logic [2:0] RS_SUPER_A = 3'h2;
	localparam logic [2:0] RS_SUPER_B = 3'h3;
	// pre-execution fault slots, lowest index handled first
	localparam int PF_PRERET = 0;
	localparam int PF_OPCODE = 1;
	localparam int PF_UNIMPL = 2;
	localparam int PF_OPERAND = 3;
	localparam int PF_UNALIGN = 4;
	localparam int PF_LENGTH = 5;
	localparam int PF_TYPE = 6;
	localparam int PF_N = 7;
	// -------------------------------------------------------------------
	// carriers
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] ip;
		logic [31:0] next_ip;
		logic [31:0] eff_addr;
		logic bad_opcode;
		logic from_data_ram;
		logic unaligned_acc;
		logic big_endian;
		logic bad_sfr;
		logic bad_sysctl;
		logic bad_reg_group;
		logic calls_over;
		logic calls_super;
		logic user_mode;
		logic modpc;
		logic dram_write;
		logic sfr_access;
		logic is_ret;
		logic branch_taken;
		logic is_call;
		logic is_bal;
		logic implicit_call;
		logic pfp_preret_flag;
		logic [2:0] ret_status;
		logic mark;
		logic bp_match;
	} pfr_instr_t;
	typedef struct packed {
		logic [7:0] ftype;
		logic [7:0] subtype;
		logic [31:0] fault_ip;
		logic fault_ip_valid;
		logic [31:0] resume_ip;
		logic resume_valid;
		logic imprecise;
		logic [31:0] opt_addr;
		logic opt_valid;
		logic [7:0] par_count;
	} pfr_rec_t;
endpackage
`default_nettype wire

// [hdl/pfr_fault_unit.sv]
// fault classification, trace event detection and fault record sequencing
//
// Contract
// - operation faults type 2, subtypes 1-4
// - code fetched from data memory: unimplemented
// - unaligned fault only when mask enables
// - little-endian unaligned accesses always complete
// - unaligned effective address in optional data
// - bad register, sysctl, register group: invalid operand
// - operation faults before execution, resume undefined
// - parallel faults only imprecise, non-zero count
// - one record per parallel fault, none after length; resume next except length
// - system call index overflow: protection length
// - length fault always precise, resume equals fault
// - trace type 1, bit-mapped subtype
// - mode bit detects, trace enable faults
// - instruction trace always; branch trace taken only
// - call trace on calls; return trace
// - prereturn trace before return when flagged
// - supervisor trace on calls and returns
// - breakpoint trace on mark or match
// - non-trace faults before trace, except prereturn
// - interrupt before trace fault, except prereturn
// - trace records instruction address, resume next, except prereturn
// - user-mode privileged access: type mismatch
// - precise bit: faults in order, exact
`default_nettype none
module pfr_fault_unit (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic instr_valid_in,
	input wire pfr_pkg::pfr_instr_t instr_in,
	input wire logic precise_faults_bit_in,
	input wire logic trace_enable_in,
	input wire logic [7:0] trace_controls_register_in,
	input wire logic unaligned_mask_in,
	input wire logic interrupt_in,
	output logic instr_ready_out,
	output logic exec_ok_out,
	output logic unaligned_complete_out,
	output logic rec_valid_out,
	output pfr_pkg::pfr_rec_t rec_out,
	output logic int_service_out
);
	// -------------------------------------------------------------------
	// decoding
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {S_IDLE, S_PRE, S_TRACE} pfr_state_t;

	// lowest set bit wins, so the slot numbering is also the reporting order
	function automatic logic [pfr_pkg::PF_N-1:0] first_set(input logic [pfr_pkg::PF_N-1:0] v);
		logic [pfr_pkg::PF_N-1:0] r;
		r = v & (~v + 7'h01);
		return r;
	endfunction

	function automatic logic [pfr_pkg::PF_N-1:0] pre_faults(input pfr_pkg::pfr_instr_t i, input logic mask,
		input logic ten, input logic [7:0] tc);
		logic [pfr_pkg::PF_N-1:0] v;
		v = '0;
		v[pfr_pkg::PF_PRERET] = i.is_ret & i.pfp_preret_flag & tc[pfr_pkg::TB_PRERET] & ten;
		v[pfr_pkg::PF_OPCODE] = i.bad_opcode;
		v[pfr_pkg::PF_UNIMPL] = i.from_data_ram;
		v[pfr_pkg::PF_OPERAND] = i.bad_sfr | i.bad_sysctl | i.bad_reg_group;
		v[pfr_pkg::PF_UNALIGN] = i.unaligned_acc & mask;
		v[pfr_pkg::PF_LENGTH] = i.calls_over;
		v[pfr_pkg::PF_TYPE] = i.user_mode & (i.modpc | i.dram_write | i.sfr_access);
		return v;
	endfunction

	pfr_state_t state_q, state_d;
	pfr_pkg::pfr_instr_t ins_q, ins_d;
	logic [pfr_pkg::PF_N-1:0] pre_q, pre_d;
	logic [7:0] trace_q, trace_d;
	logic precise_q, precise_d;
	logic irq_q, irq_d;
	logic [7:0] par_q, par_d;
	logic rec_valid_q, rec_valid_d;
	pfr_pkg::pfr_rec_t rec_q, rec_d;
	logic int_q, int_d;
	logic take;
	logic [pfr_pkg::PF_N-1:0] pre_now;
	logic [7:0] trace_now;
	logic [pfr_pkg::PF_N-1:0] pick;

	assign instr_ready_out = (state_q == S_IDLE);
	assign take = ce_in & instr_valid_in & instr_ready_out;
	assign pre_now = pre_faults(instr_in, unaligned_mask_in, trace_enable_in, trace_controls_register_in);
	assign pick = first_set(pre_q);
	// the instruction only proceeds when nothing stops it beforehand
	assign exec_ok_out = instr_valid_in & instr_ready_out & (pre_now == '0);
	// little-endian regions are fixed up internally whatever the mask
	assign unaligned_complete_out = instr_valid_in & instr_in.unaligned_acc & ~instr_in.big_endian;

	always_comb begin
		trace_now = '0;
		trace_now[pfr_pkg::TB_INSTR] = 1'b1;
		trace_now[pfr_pkg::TB_BRANCH] = instr_in.branch_taken & ~instr_in.is_bal & ~instr_in.is_call;
		trace_now[pfr_pkg::TB_CALL] = instr_in.is_call | instr_in.is_bal | instr_in.implicit_call;
		trace_now[pfr_pkg::TB_RETURN] = instr_in.is_ret;
		trace_now[pfr_pkg::TB_SUPER] = instr_in.calls_super | (instr_in.is_ret &
			(instr_in.ret_status == pfr_pkg::RS_SUPER_A || instr_in.ret_status == pfr_pkg::RS_SUPER_B));
		trace_now[pfr_pkg::TB_BREAK] = instr_in.mark | instr_in.bp_match;
		// detection needs the mode bit, faulting also needs trace enable
		trace_now = trace_now & trace_controls_register_in & {8{trace_enable_in}} & pfr_pkg::TRACE_LEGAL;
	end

	// -------------------------------------------------------------------
	// sequencer
	// -------------------------------------------------------------------
	// a new instruction waits until every record has gone out, so records never interleave

	always_comb begin
		logic [pfr_pkg::PF_N-1:0] nt;
		nt = '0;
		state_d = state_q;
		ins_d = ins_q;
		pre_d = pre_q;
		trace_d = trace_q;
		precise_d = precise_q;
		irq_d = irq_q;
		par_d = par_q;
		rec_valid_d = 1'b0;
		rec_d = rec_q;
		int_d = 1'b0;
		unique case (state_q)
			S_IDLE: begin
				if (take) begin
					ins_d = instr_in;
					pre_d = pre_now;
					trace_d = trace_now;
					irq_d = interrupt_in;
					precise_d = precise_faults_bit_in;
					nt = pre_now;
					nt[pfr_pkg::PF_PRERET] = 1'b0;
					// concurrent faults are only reported together when imprecise
					par_d = (!precise_faults_bit_in && $countones(nt) > 1) ?
						8'($countones(nt)) : 8'h00;
					if (pre_now != '0)
						state_d = S_PRE;
					else if (trace_now != '0)
						state_d = S_TRACE;
				end
			end
			S_PRE: begin
				rec_valid_d = 1'b1;
				rec_d = '0;
				rec_d.fault_ip = ins_q.ip;
				rec_d.fault_ip_valid = 1'b1;
				rec_d.imprecise = ~precise_q;
				rec_d.par_count = par_q;
				if (par_q != 8'h00) begin
					rec_d.resume_ip = ins_q.next_ip;
					rec_d.resume_valid = 1'b1;
				end
				unique case (1'b1)
					pick[pfr_pkg::PF_PRERET]: begin
						rec_d.ftype = pfr_pkg::FT_TRACE;
						rec_d.subtype = 8'(1 << pfr_pkg::TB_PRERET);
						rec_d.fault_ip_valid = 1'b0;
						rec_d.resume_ip = ins_q.ip;
						rec_d.resume_valid = 1'b1;
						rec_d.imprecise = 1'b0;
						rec_d.par_count = 8'h00;
					end
					pick[pfr_pkg::PF_OPCODE]: begin
						rec_d.ftype = pfr_pkg::FT_OPER;
						rec_d.subtype = pfr_pkg::ST_INV_OPCODE;
					end
					pick[pfr_pkg::PF_UNIMPL]: begin
						rec_d.ftype = pfr_pkg::FT_OPER;
						rec_d.subtype = pfr_pkg::ST_UNIMPL;
					end
					pick[pfr_pkg::PF_OPERAND]: begin
						rec_d.ftype = pfr_pkg::FT_OPER;
						rec_d.subtype = pfr_pkg::ST_INV_OPERAND;
					end
					pick[pfr_pkg::PF_UNALIGN]: begin
						rec_d.ftype = pfr_pkg::FT_OPER;
						rec_d.subtype = pfr_pkg::ST_UNALIGNED;
						rec_d.opt_addr = ins_q.eff_addr;
						rec_d.opt_valid = 1'b1;
					end
					pick[pfr_pkg::PF_LENGTH]: begin
						rec_d.ftype = pfr_pkg::FT_PROT;
						rec_d.subtype = pfr_pkg::ST_LENGTH;
						rec_d.resume_ip = ins_q.ip;
						rec_d.resume_valid = 1'b1;
						rec_d.imprecise = 1'b0;
					end
					default: begin
						rec_d.ftype = pfr_pkg::FT_TYPE;
						rec_d.subtype = pfr_pkg::ST_MISMATCH;
					end
				endcase
				pre_d = pre_q & ~pick;
				// precise mode stops at the first real fault; length is always precise
				if (!pick[pfr_pkg::PF_PRERET] && (precise_q || pick[pfr_pkg::PF_LENGTH]))
					pre_d = '0;
				if (pre_d == '0)
					state_d = (trace_q != '0) ? S_TRACE : S_IDLE;
			end
			S_TRACE: begin
				// the interrupt pulse goes out first, the trace record one cycle later
				if (irq_q) begin
					int_d = 1'b1;
					irq_d = 1'b0;
				end else begin
					rec_valid_d = 1'b1;
					rec_d = '0;
					rec_d.ftype = pfr_pkg::FT_TRACE;
					rec_d.subtype = trace_q;
					rec_d.fault_ip = ins_q.ip;
					rec_d.fault_ip_valid = 1'b1;
					rec_d.resume_ip = ins_q.next_ip;
					rec_d.resume_valid = 1'b1;
					trace_d = '0;
					state_d = S_IDLE;
				end
			end
		endcase
	end

	// reset does not wait for the clock enable
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= S_IDLE;
			ins_q <= '0;
			pre_q <= '0;
			trace_q <= '0;
			precise_q <= 1'b0;
			irq_q <= 1'b0;
			par_q <= 8'h00;
			rec_valid_q <= 1'b0;
			rec_q <= '0;
			int_q <= 1'b0;
		end else if (ce_in) begin
			state_q <= state_d;
			ins_q <= ins_d;
			pre_q <= pre_d;
			trace_q <= trace_d;
			precise_q <= precise_d;
			irq_q <= irq_d;
			par_q <= par_d;
			rec_valid_q <= rec_valid_d;
			rec_q <= rec_d;
			int_q <= int_d;
		end
	end

	assign rec_valid_out = rec_valid_q;
	assign rec_out = rec_q;
	assign int_service_out = int_q;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	op_subtype_a: assert property (rec_valid_out && rec_out.ftype == pfr_pkg::FT_OPER |->
		rec_out.subtype inside {[8'h01:8'h04]} && !rec_out.resume_valid || rec_out.par_count != 8'h00)
		else $error("operation fault subtype or resume wrong");
	unal_mask_a: assert property (take && instr_in.unaligned_acc && !unaligned_mask_in |=>
		!pre_q[pfr_pkg::PF_UNALIGN]) else $error("masked unaligned access raised a fault");
	opt_addr_a: assert property (rec_valid_out && rec_out.subtype == pfr_pkg::ST_UNALIGNED &&
		rec_out.ftype == pfr_pkg::FT_OPER |-> rec_out.opt_valid && rec_out.opt_addr == ins_q.eff_addr)
		else $error("unaligned record lacks effective address");
	par_only_a: assert property (rec_valid_out && rec_out.par_count != 8'h00 |-> !precise_q)
		else $error("parallel count under precise mode");
	len_prec_a: assert property (rec_valid_out && rec_out.ftype == pfr_pkg::FT_PROT |->
		rec_out.resume_valid && rec_out.resume_ip == rec_out.fault_ip && !rec_out.imprecise)
		else $error("length fault not precise");
	trc_sub_a: assert property (rec_valid_out && rec_out.ftype == pfr_pkg::FT_TRACE |->
		rec_out.subtype[0] == 1'b0 && rec_out.subtype != 8'h00) else $error("bad trace subtype");
	trc_en_a: assert property (take && !trace_enable_in |=> trace_q == 8'h00 &&
		!pre_q[pfr_pkg::PF_PRERET]) else $error("trace captured while disabled");
	pre_first_a: assert property (take && pre_now[pfr_pkg::PF_PRERET] |-> ##2 rec_valid_out &&
		rec_out.subtype == 8'(1 << pfr_pkg::TB_PRERET)) else $error("prereturn not handled first");
	int_first_a: assert property (int_service_out |-> ##1 rec_valid_out &&
		rec_out.ftype == pfr_pkg::FT_TRACE) else $error("trace not delivered after interrupt");
	type_rec_a: assert property (rec_valid_out && rec_out.ftype == pfr_pkg::FT_TYPE |->
		rec_out.subtype == pfr_pkg::ST_MISMATCH && !rec_out.resume_valid || rec_out.par_count != 8'h00)
		else $error("type fault record wrong");
	trc_rec_a: assert property (rec_valid_out && rec_out.ftype == pfr_pkg::FT_TRACE &&
		rec_out.subtype != 8'(1 << pfr_pkg::TB_PRERET) |-> rec_out.fault_ip_valid &&
		rec_out.fault_ip == ins_q.ip && rec_out.resume_ip == ins_q.next_ip)
		else $error("trace record addresses wrong");
	ce_hold_a: assert property (!ce_in |=> $stable(state_q) && $stable(pre_q) && $stable(rec_q))
		else $error("state moved while clock enable low");
	// worst case: prereturn, five faults, interrupt pulse and trace record
	busy_bound_a: assert property (take |-> ##[1:10] instr_ready_out)
		else $error("sequencer did not return to idle");

	preret_c: cover property (take && pre_now[pfr_pkg::PF_PRERET]);
	par_c: cover property (rec_valid_out && rec_out.par_count > 8'h01);
	irq_c: cover property (int_service_out);
	len_c: cover property (rec_valid_out && rec_out.ftype == pfr_pkg::FT_PROT);
	multi_trc_c: cover property (rec_valid_out && rec_out.ftype == pfr_pkg::FT_TRACE && $countones(rec_out.subtype) > 1);
endmodule
`default_nettype wire

// [tb/pfr_fault_unit_tb_top.sv]
// self-checking bench for the fault reporting unit
`default_nettype none
module pfr_fault_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'h0;
	logic rst_in = 1'h1;
	logic ce_in = 1'h1;
	logic instr_valid_in = 1'h0;
	pfr_pkg::pfr_instr_t instr_in = '0;
	logic precise_faults_bit_in = 1'h1;
	logic trace_enable_in = 1'h0;
	logic [7:0] trace_controls_register_in = 8'h00;
	logic unaligned_mask_in = 1'h0;
	logic interrupt_in = 1'h0;
	logic instr_ready_out;
	logic exec_ok_out;
	logic unaligned_complete_out;
	logic rec_valid_out;
	logic int_service_out;
	pfr_pkg::pfr_rec_t rec_out;
	pfr_pkg::pfr_rec_t seen[$];
	pfr_pkg::pfr_rec_t r;
	pfr_pkg::pfr_rec_t irq_mark;
	pfr_pkg::pfr_instr_t base;
	pfr_pkg::pfr_instr_t d;
	int error_cnt = 0;
	int comparisons = 0;

	always #25 clk_in = ~clk_in;

	pfr_fault_unit u_pfr_fault_unit (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.precise_faults_bit_in(precise_faults_bit_in), .trace_enable_in(trace_enable_in),
		.trace_controls_register_in(trace_controls_register_in), .unaligned_mask_in(unaligned_mask_in),
		.interrupt_in(interrupt_in), .instr_ready_out(instr_ready_out), .exec_ok_out(exec_ok_out),
		.unaligned_complete_out(unaligned_complete_out), .rec_valid_out(rec_valid_out),
		.rec_out(rec_out), .int_service_out(int_service_out)
	);

	// ----------------------------------------
	// record capture and compare tasks
	// ----------------------------------------
	// an interrupt pulse is queued as type FF so its place in the order is checked too
	always @(posedge clk_in) begin
		if (rec_valid_out === 1'h1) seen.push_back(rec_out);
		if (int_service_out === 1'h1) seen.push_back(irq_mark);
	end

	task automatic end_of_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic rec(input logic [7:0] ft, input logic [7:0] st);
		r = '0;
		if (seen.size() > 0) r = seen.pop_front();
		chk(r.ftype, ft, "fault type");
		chk(r.subtype, st, "subtype");
	endtask

	// offers one descriptor, waits for the sequencer to go idle, counts records
	task automatic run(input pfr_pkg::pfr_instr_t ins, input logic ok, input int n);
		int k;
		seen.delete();
		instr_in = ins;
		instr_valid_in = 1'h1;
		@(negedge clk_in);
		chk(exec_ok_out, ok, "exec ok");
		chk(unaligned_complete_out, ins.unaligned_acc & ~ins.big_endian, "unaligned complete");
		@(posedge clk_in);
		#1;
		instr_valid_in = 1'h0;
		k = 0;
		while (instr_ready_out !== 1'h1 && k < 20) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		if (k == 20) begin
			error_cnt++;
			$display("MISMATCH %0t sequencer stuck busy", $time);
			end_of_test();
		end
		repeat (3) @(posedge clk_in);
		#1;
		chk(seen.size(), n, "record count");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int i;
		irq_mark = '0;
		irq_mark.ftype = 8'hFF;
		base = '0;
		base.ip = 32'h0000_1000;
		base.next_ip = 32'h0000_1004;
		base.eff_addr = 32'h0000_2002;
		repeat (6) @(posedge clk_in);
		#1;
		rst_in = 1'h0;
		chk(instr_ready_out, 1'h1, "ready after reset");
		// with the clock enable low an offered faulting instruction must leave no record
		ce_in = 1'h0;
		d = base;
		d.bad_opcode = 1'h1;
		run(d, 1'h0, 0);
		ce_in = 1'h1;
		d = base; d.bad_opcode = 1'h1; run(d, 1'h0, 1); rec(8'h02, 8'h01);
		chk(r.resume_valid, 1'h0, "resume valid");
		d = base; d.from_data_ram = 1'h1; run(d, 1'h0, 1); rec(8'h02, 8'h02);
		d = base; d.bad_sfr = 1'h1; run(d, 1'h0, 1); rec(8'h02, 8'h04);
		d = base; d.bad_sysctl = 1'h1; run(d, 1'h0, 1); rec(8'h02, 8'h04);
		d = base; d.bad_reg_group = 1'h1; run(d, 1'h0, 1); rec(8'h02, 8'h04);
		d = base; d.unaligned_acc = 1'h1; run(d, 1'h1, 0);
		unaligned_mask_in = 1'h1;
		run(d, 1'h0, 1); rec(8'h02, 8'h03);
		chk(r.opt_addr, base.eff_addr, "unaligned address");
		chk(r.opt_valid, 1'h1, "unaligned address valid");
		d.big_endian = 1'h1; run(d, 1'h0, 1); rec(8'h02, 8'h03);
		unaligned_mask_in = 1'h0;
		precise_faults_bit_in = 1'h0;
		d = base; d.calls_over = 1'h1; run(d, 1'h0, 1); rec(8'h07, 8'h02);
		chk(r.resume_ip, base.ip, "length resume");
		chk(r.fault_ip, base.ip, "length address");
		chk(r.imprecise, 1'h0, "length precise");
		for (i = 0; i < 3; i++) begin
			d = base; d.user_mode = 1'h1; d.modpc = (i == 0); d.dram_write = (i == 1); d.sfr_access = (i == 2);
			run(d, 1'h0, 1); rec(8'h0A, 8'h01);
		end
		d = base; d.bad_opcode = 1'h1; d.bad_sfr = 1'h1; run(d, 1'h0, 2); rec(8'h02, 8'h01);
		chk(r.par_count, 2, "parallel count");
		chk(r.resume_ip, base.next_ip, "parallel resume");
		chk(r.imprecise, 1'h1, "parallel imprecise");
		rec(8'h02, 8'h04);
		chk(r.par_count, 2, "parallel count");
		precise_faults_bit_in = 1'h1;
		run(d, 1'h0, 1); rec(8'h02, 8'h01);
		// ----------------------------------------
		// trace modes, one bit at a time, then combined and disabled
		// ----------------------------------------
		trace_enable_in = 1'h1;
		for (i = 1; i < 10; i++) begin
			d = base; d.branch_taken = (i == 2); d.is_call = (i == 3); d.is_ret = (i == 4 || i == 5 || i == 8);
			d.pfp_preret_flag = (i == 5); d.calls_super = (i == 6); d.mark = (i == 7); d.bp_match = (i == 9);
			d.ret_status = (i == 8) ? pfr_pkg::RS_SUPER_A : pfr_pkg::RS_SUPER_B;
			trace_controls_register_in = 8'h01 << (i == 8 ? 6 : (i == 9 ? 7 : i));
			run(d, i != 5, 1); rec(8'h01, trace_controls_register_in);
			chk(r.resume_ip, i == 5 ? base.ip : base.next_ip, "trace resume");
			chk(r.fault_ip_valid, i != 5, "trace address valid");
			if (i != 5) chk(r.fault_ip, base.ip, "trace address");
		end
		trace_controls_register_in = 8'h0E;
		d = base; d.branch_taken = 1'h1; run(d, 1'h1, 1); rec(8'h01, 8'h06);
		d.is_bal = 1'h1; trace_controls_register_in = 8'h04; run(d, 1'h1, 0);
		trace_controls_register_in = 8'h08; run(d, 1'h1, 1); rec(8'h01, 8'h08);
		d = base; d.implicit_call = 1'h1; run(d, 1'h1, 1); rec(8'h01, 8'h08);
		d = base; d.mark = 1'h1; trace_controls_register_in = 8'h00; run(d, 1'h1, 0);
		trace_enable_in = 1'h0; trace_controls_register_in = 8'hFE; run(d, 1'h1, 0);
		// ----------------------------------------
		// ordering against faults and interrupts
		// ----------------------------------------
		trace_enable_in = 1'h1;
		interrupt_in = 1'h1;
		trace_controls_register_in = 8'h02;
		d = base; d.bad_opcode = 1'h1; run(d, 1'h0, 3); rec(8'h02, 8'h01);
		rec(8'hFF, 8'h00); rec(8'h01, 8'h02);
		trace_controls_register_in = 8'h22;
		d.is_ret = 1'h1; d.pfp_preret_flag = 1'h1; run(d, 1'h0, 4); rec(8'h01, 8'h20);
		rec(8'h02, 8'h01); rec(8'hFF, 8'h00); rec(8'h01, 8'h02);
		interrupt_in = 1'h0;
		end_of_test();
	end
endmodule
`default_nettype wire
